// File: core/pss_pkg.sv
// Package for the scan supervisor: map, fields, timing
package pss_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned SHORT_LOSS_MS = 20;
  localparam int unsigned NUM_TASKS     = 8;
  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_WD_LIMIT = 8'h08;
  localparam logic [7:0] A_SCAN_MAX = 8'h0c;
  localparam logic [7:0] A_SCAN_MIN = 8'h10;
  localparam logic [7:0] A_LATEST_CYCLE_TIME = 8'h14;
  localparam logic [7:0] A_IRQ_STAT = 8'h18;
  localparam logic [7:0] A_IRQ_MASK = 8'h1c;
  localparam logic [7:0] A_TASK_SEL = 8'h20;
  localparam logic [7:0] A_TASK_IVL = 8'h24;
  localparam logic [7:0] A_TASK_ENA = 8'h28;
  localparam logic [7:0] A_TMR_PRE  = 8'h2c;
  localparam logic [7:0] A_TMR_ET   = 8'h30;
  // CTRL bits
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_TMR_EN = 1;
  // IRQ status bits
  localparam int IRQ_WDOG    = 0;
  localparam int IRQ_RESTART = 1;
  localparam int IRQ_TASK    = 2;
  localparam int IRQ_TMR_Q   = 3;
  localparam logic [15:0] WD_LIMIT_RST = 16'h0064;
  localparam logic [31:0] SCAN_MIN_RST = 32'hffffffff;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    PSS_STOP    = 2'b00,
    PSS_RUN     = 2'b01,
    PSS_HOLD    = 2'b10,
    PSS_FAULT   = 2'b11
  } pss_mode_t;

  // Signals from the program sequencer
  typedef struct packed {
    logic scan_start;
    logic wd_clear;
    logic tmr_exec;
    logic tmr_in;
  } pss_seq_t;
endpackage

// File: core/pss_supervisor.sv
// Scan supervisor: scan timing, watchdog, tasks, power loss, timer
//
// Functional notes
// - Sequencer runs program first to last step and repeats unless interrupted.
// - Scan period is measured from one step zero start to the next.
// - Largest, smallest and latest scan times kept, each in milliseconds.
// - Watchdog overrun halts execution at once and forces all outputs off.
// - Watchdog limit is 1 to 65535 ms in 1 ms steps.
// - Watchdog clear call resets accumulated watchdog time to zero.
// - Watchdog error clears only by manual reset, restart or STOP entry.
// - Power loss up to 20 ms suspends execution, holds outputs, then resumes.
// - Watchdog and task interval timing keep counting while suspended.
// - Power loss longer than 20 ms causes full restart on recovery.
// - Timed tasks fire at a fixed interval independent of the scan.
// - Interrupt request runs its task at once, pre-empting the scan.
// - At most eight tasks total, of any mix of kinds.
// - Timer counts up in 1 ms steps over a 32-bit range.
// - Timer elapsed value updates only when its block executes.
// - On-delay output turns on when elapsed equals preset.
// - Timer error at most one scan plus delay to block execution.
`timescale 1ns/10ps
module pss_supervisor #(
  parameter int unsigned TICK_CYCLES = pss_pkg::TICK_CYCLES,
  parameter int unsigned LOSS_MS     = pss_pkg::SHORT_LOSS_MS
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  // AXI4-Lite slave
  input  wire logic [7:0]         s_awaddr,
  input  wire logic               s_awvalid,
  output logic                    s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output logic                    s_wready,
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire logic               s_bready,
  input  wire logic [7:0]         s_araddr,
  input  wire logic               s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire logic               s_rready,
  // Sequencer and field
  input  wire pss_pkg::pss_seq_t  seq,
  input  wire logic               manual_reset,
  input  wire logic               power_fail,
  input  wire logic [7:0]         ext_irq,
  input  wire logic [7:0]         int_irq,
  // Outputs
  output logic                    exec_enable,
  output logic                    outputs_enable,
  output logic                    restart_req,
  output logic [7:0]              task_run,
  output logic                    on_delay_q,
  output logic                    irq
);
  localparam int TW = $clog2(TICK_CYCLES);

  logic [TW-1:0]      tick_cnt;
  logic               tick;
  pss_pkg::pss_mode_t mode;
  logic [1:0]         ctrl;
  logic [15:0]        wd_limit;
  logic [15:0]        cycle_watchdog;
  logic [31:0]        scan_ms;
  logic [31:0]        scan_max, scan_min, latest_cycle_time;
  logic               scan_seen;
  logic [7:0]         loss_ms;
  logic               long_loss;
  logic [3:0]         irq_stat, irq_mask;
  logic [2:0]         task_sel;
  logic [31:0]        task_ivl [pss_pkg::NUM_TASKS];
  logic [31:0]        task_cnt [pss_pkg::NUM_TASKS];
  logic [7:0]         task_ena;
  logic [7:0]         timed_fire;
  logic [31:0]        tmr_pre, tmr_et, tmr_acc;
  logic               run_q;
  logic [3:0]         evt;
  logic               wd_over;
  logic               aw_held, w_held;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic               wr_do, rd_do;
  logic [31:0]        next_rdata;
  logic [1:0]         next_rresp;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= pss_pkg::A_TMR_ET) && (a[1:0] == 2'b00);
  endfunction

  // Millisecond timebase; stops with the clock enable like everything else
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (clk_en) begin
      tick <= (tick_cnt == TW'(TICK_CYCLES - 1));
      if (tick_cnt == TW'(TICK_CYCLES - 1)) tick_cnt <= '0;
      else tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign wd_over = (cycle_watchdog >= wd_limit) && (mode == pss_pkg::PSS_RUN);

  // Operating mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= pss_pkg::PSS_STOP;
      run_q <= 1'b0;
      restart_req <= 1'b0;
    end else if (clk_en) begin
      run_q <= ctrl[pss_pkg::CTRL_RUN];
      restart_req <= 1'b0;
      unique case (mode)
        pss_pkg::PSS_STOP: if (ctrl[pss_pkg::CTRL_RUN] && !run_q) begin
          mode <= pss_pkg::PSS_RUN;
          restart_req <= 1'b1;
        end
        pss_pkg::PSS_RUN: begin
          if (!ctrl[pss_pkg::CTRL_RUN]) mode <= pss_pkg::PSS_STOP;
          else if (wd_over && tick) mode <= pss_pkg::PSS_FAULT;
          else if (power_fail) mode <= pss_pkg::PSS_HOLD;
        end
        pss_pkg::PSS_HOLD: begin
          if (!power_fail) begin
            mode <= pss_pkg::PSS_RUN;
            restart_req <= long_loss;
          end
        end
        pss_pkg::PSS_FAULT: begin
          // Latched until manual reset or STOP; a restart only clears it by passing through STOP
          if (manual_reset || !ctrl[pss_pkg::CTRL_RUN])
            mode <= pss_pkg::PSS_STOP;
        end
      endcase
      if (manual_reset && mode != pss_pkg::PSS_FAULT)
        mode <= pss_pkg::PSS_STOP;
    end
  end

  // Execution gates; outputs held during short loss, dropped on fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_enable    <= 1'b0;
      outputs_enable <= 1'b0;
    end else if (clk_en) begin
      exec_enable    <= (mode == pss_pkg::PSS_RUN) && !(wd_over && tick)
                        && !power_fail;
      outputs_enable <= (mode == pss_pkg::PSS_RUN && !(wd_over && tick))
                        || mode == pss_pkg::PSS_HOLD;
    end
  end

  // Power loss duration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_ms   <= '0;
      long_loss <= 1'b0;
    end else if (clk_en) begin
      if (!power_fail) begin
        loss_ms   <= '0;
        long_loss <= 1'b0;
      end else if (tick) begin
        if (loss_ms != 8'hff) loss_ms <= loss_ms + 1'b1;
        if (loss_ms >= 8'(LOSS_MS)) long_loss <= 1'b1;
      end
    end
  end

  // Watchdog; keeps counting in HOLD
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycle_watchdog <= '0;
    end else if (clk_en) begin
      if (seq.scan_start || seq.wd_clear || mode == pss_pkg::PSS_STOP)
        cycle_watchdog <= '0;
      else if (tick && cycle_watchdog != 16'hffff)
        cycle_watchdog <= cycle_watchdog + 1'b1;
    end
  end

  // Scan time statistics
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_ms           <= '0;
      scan_max          <= '0;
      scan_min          <= pss_pkg::SCAN_MIN_RST;
      latest_cycle_time <= '0;
      scan_seen         <= 1'b0;
    end else if (clk_en) begin
      if (seq.scan_start) begin
        scan_ms <= '0;
        scan_seen <= 1'b1;
        if (scan_seen) begin
          latest_cycle_time <= scan_ms;
          if (scan_ms > scan_max) scan_max <= scan_ms;
          if (scan_ms < scan_min) scan_min <= scan_ms;
        end
      end else if (tick) begin
        scan_ms <= scan_ms + 1'b1;
      end
    end
  end

  // Timed and interrupt tasks, eight slots of any kind
  for (genvar i = 0; i < pss_pkg::NUM_TASKS; i++) begin : g_task
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        task_cnt[i]   <= '0;
        timed_fire[i] <= 1'b0;
      end else if (clk_en) begin
        timed_fire[i] <= 1'b0;
        if (!task_ena[i] || mode == pss_pkg::PSS_STOP) begin
          task_cnt[i] <= '0;
        end else if (tick) begin
          // Interval counts in 10 ms units of tick-rate ms
          if (task_cnt[i] + 1 >= task_ivl[i] * 10) begin
            task_cnt[i]   <= '0;
            timed_fire[i] <= 1'b1;
          end else begin
            task_cnt[i] <= task_cnt[i] + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      task_run <= '0;
    end else if (clk_en) begin
      if (mode == pss_pkg::PSS_RUN && !power_fail)
        task_run <= task_ena & (timed_fire | ext_irq | int_irq);
      else
        task_run <= '0;
    end
  end

  // On-delay timer, sampled only when its block executes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_acc    <= '0;
      tmr_et     <= '0;
      on_delay_q <= 1'b0;
    end else if (clk_en) begin
      if (!seq.tmr_in || !ctrl[pss_pkg::CTRL_TMR_EN]) tmr_acc <= '0;
      else if (tick && tmr_acc != 32'hffffffff)
        tmr_acc <= tmr_acc + 1'b1;
      if (seq.tmr_exec) begin
        tmr_et     <= (tmr_acc >= tmr_pre) ? tmr_pre : tmr_acc;
        on_delay_q <= seq.tmr_in && (tmr_acc >= tmr_pre);
      end
    end
  end

  // Interrupt status, cleared by reading it; set wins
  assign evt = {on_delay_q == 1'b0 && seq.tmr_exec && seq.tmr_in &&
                tmr_acc >= tmr_pre, |timed_fire, restart_req,
                wd_over && tick && mode == pss_pkg::PSS_RUN};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else if (clk_en) begin
      irq_stat <= (rd_do && s_araddr == pss_pkg::A_IRQ_STAT ? 4'h0 : irq_stat)
                  | evt;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // AXI4-Lite write path
  assign wr_do = aw_held && w_held && !s_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      s_bvalid <= 1'b0;
      s_bresp  <= pss_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
      end
      if (wr_do) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= mapped(aw_addr) ? pss_pkg::RESP_OKAY
                                    : pss_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // Ready flags follow the next holding state, so each comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_arready <= 1'b1;
    end else if (clk_en) begin
      s_awready <= !(wr_do || aw_held || (s_awvalid && s_awready) ||
                     (s_bvalid && !s_bready));
      s_wready  <= !(wr_do || w_held || (s_wvalid && s_wready) ||
                     (s_bvalid && !s_bready));
      s_arready <= !(rd_do || (s_rvalid && !s_rready));
    end
  end

  // Writable registers; full-word writes only matter for wide fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= '0;
      wd_limit <= pss_pkg::WD_LIMIT_RST;
      irq_mask <= '0;
      task_sel <= '0;
      task_ena <= '0;
      tmr_pre  <= '0;
      for (int k = 0; k < pss_pkg::NUM_TASKS; k++) task_ivl[k] <= 32'h1;
    end else if (clk_en && wr_do) begin
      unique case (aw_addr)
        pss_pkg::A_CTRL:     ctrl <= w_data[1:0];
        pss_pkg::A_WD_LIMIT: if (w_data[15:0] != 16'h0)
          wd_limit <= w_data[15:0];
        pss_pkg::A_IRQ_MASK: irq_mask <= w_data[3:0];
        pss_pkg::A_TASK_SEL: task_sel <= w_data[2:0];
        pss_pkg::A_TASK_IVL: if (w_data != 32'h0)
          task_ivl[task_sel] <= w_data;
        pss_pkg::A_TASK_ENA: task_ena <= w_data[7:0];
        pss_pkg::A_TMR_PRE:  tmr_pre <= w_data;
        default: ;
      endcase
    end
  end

  // AXI4-Lite read path, one cycle after the address
  assign rd_do = s_arvalid && s_arready;
  always_comb begin
    next_rresp = pss_pkg::RESP_OKAY;
    unique case (s_araddr)
      pss_pkg::A_CTRL:     next_rdata = {30'h0, ctrl};
      pss_pkg::A_STATUS:   next_rdata = {25'h0, restart_req, long_loss,
                                         power_fail, outputs_enable,
                                         exec_enable, mode};
      pss_pkg::A_WD_LIMIT: next_rdata = {16'h0, wd_limit};
      pss_pkg::A_SCAN_MAX: next_rdata = scan_max;
      pss_pkg::A_SCAN_MIN: next_rdata = scan_min;
      pss_pkg::A_LATEST_CYCLE_TIME: next_rdata = latest_cycle_time;
      pss_pkg::A_IRQ_STAT: next_rdata = {28'h0, irq_stat};
      pss_pkg::A_IRQ_MASK: next_rdata = {28'h0, irq_mask};
      pss_pkg::A_TASK_SEL: next_rdata = {29'h0, task_sel};
      pss_pkg::A_TASK_IVL: next_rdata = task_ivl[task_sel];
      pss_pkg::A_TASK_ENA: next_rdata = {24'h0, task_ena};
      pss_pkg::A_TMR_PRE:  next_rdata = tmr_pre;
      pss_pkg::A_TMR_ET:   next_rdata = tmr_et;
      default: begin
        next_rdata = 32'h0;
        next_rresp = pss_pkg::RESP_SLVERR;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= pss_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rd_do) begin
        s_rvalid <= 1'b1;
        s_rdata  <= next_rdata;
        s_rresp  <= next_rresp;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  property p_wdog_off;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && mode == pss_pkg::PSS_RUN && wd_over && tick)
      |=> !outputs_enable && !exec_enable;
  endproperty
  a_wdog_off: assert property (p_wdog_off)
    else $error("outputs stay on after watchdog overrun");

  property p_fault_latch;
    @(posedge aclk) disable iff (!aresetn)
    (mode == pss_pkg::PSS_FAULT && clk_en && !manual_reset &&
     ctrl[pss_pkg::CTRL_RUN]) |=> mode == pss_pkg::PSS_FAULT;
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("watchdog fault left without reset or stop");

  property p_wd_clear;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && (seq.wd_clear || seq.scan_start)) |=> cycle_watchdog == 0;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("watchdog time not cleared");

  property p_wd_count;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && tick && !seq.wd_clear && !seq.scan_start &&
     mode != pss_pkg::PSS_STOP && cycle_watchdog < 16'hfffe)
      |=> cycle_watchdog == $past(cycle_watchdog) + 1;
  endproperty
  a_wd_count: assert property (p_wd_count)
    else $error("watchdog missed a tick");

  property p_hold_outputs;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && mode == pss_pkg::PSS_HOLD) |=> outputs_enable && !exec_enable;
  endproperty
  a_hold_outputs: assert property (p_hold_outputs)
    else $error("short loss did not hold outputs");

  property p_latest;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && seq.scan_start && scan_seen)
      |=> latest_cycle_time == $past(scan_ms);
  endproperty
  a_latest: assert property (p_latest)
    else $error("latest scan time not captured");

  property p_minmax;
    @(posedge aclk) disable iff (!aresetn)
    (scan_seen && latest_cycle_time != 0) |-> scan_min <= scan_max;
  endproperty
  a_minmax: assert property (p_minmax)
    else $error("scan minimum above maximum");

  property p_on_delay;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && seq.tmr_exec && seq.tmr_in && tmr_acc == tmr_pre)
      |=> on_delay_q;
  endproperty
  a_on_delay: assert property (p_on_delay)
    else $error("on-delay output late");

  property p_et_frozen;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && !seq.tmr_exec) |=> $stable(tmr_et);
  endproperty
  a_et_frozen: assert property (p_et_frozen)
    else $error("elapsed value moved without block execution");

  property p_long_restart;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && mode == pss_pkg::PSS_HOLD && !power_fail && long_loss)
      |=> restart_req;
  endproperty
  a_long_restart: assert property (p_long_restart)
    else $error("long power loss without restart");

  c_fault:   cover property (@(posedge aclk) mode == pss_pkg::PSS_FAULT);
  c_hold:    cover property (@(posedge aclk) mode == pss_pkg::PSS_HOLD);
  c_task:    cover property (@(posedge aclk) |task_run);
  c_tmr_q:   cover property (@(posedge aclk) on_delay_q);
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the scan supervisor
`timescale 1ns/10ps
module tb_top;
  localparam int TK = 4;
  logic              aclk;
  logic              aresetn;
  logic [7:0]        s_awaddr;
  logic              s_awvalid;
  logic              s_awready;
  logic [31:0]       s_wdata;
  logic              s_wvalid;
  logic              s_wready;
  logic [1:0]        s_bresp;
  logic              s_bvalid;
  logic              s_bready;
  logic [7:0]        s_araddr;
  logic              s_arvalid;
  logic              s_arready;
  logic [31:0]       s_rdata;
  logic [1:0]        s_rresp;
  logic              s_rvalid;
  logic              s_rready;
  pss_pkg::pss_seq_t seq;
  logic              manual_reset;
  logic              power_fail;
  logic [7:0]        ext_irq;
  logic [7:0]        int_irq;
  logic              exec_enable;
  logic              outputs_enable;
  logic              restart_req;
  logic [7:0]        task_run;
  logic              on_delay_q;
  logic              irq;
  int                bad_count;
  int                checks_done;
  int                rs_cnt;
  int                tr_cnt;
  int                seed;
  logic [33:0]       rd_q[$];
  logic [1:0]        wr_q[$];
  logic [31:0]       rv;
  logic              seen;
  logic              tr_prev;

  pss_supervisor #(.TICK_CYCLES(TK), .LOSS_MS(20)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .seq(seq),
    .manual_reset(manual_reset), .power_fail(power_fail),
    .ext_irq(ext_irq), .int_irq(int_irq), .exec_enable(exec_enable),
    .outputs_enable(outputs_enable), .restart_req(restart_req),
    .task_run(task_run), .on_delay_q(on_delay_q), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic mism(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
    mism(g, e);
  endtask
  task automatic cmp_wr(input logic [1:0] g, input logic [1:0] e);
    mism({32'h0, g}, {32'h0, e});
  endtask
  task automatic cmp_pin(input logic [31:0] g, input logic [31:0] e);
    mism({2'b00, g}, {2'b00, e});
  endtask

  // Monitor takes the oldest note whenever a response is accepted
  always @(posedge aclk) begin
    if (s_rvalid === 1'b1 && s_rready === 1'b1 && rd_q.size() > 0)
      cmp_rd({s_rresp, s_rdata}, rd_q.pop_front());
    if (s_bvalid === 1'b1 && s_bready === 1'b1 && wr_q.size() > 0)
      cmp_wr(s_bresp, wr_q.pop_front());
  end
  always @(posedge aclk) begin
    if (restart_req === 1'b1) rs_cnt <= rs_cnt + 1;
    if (task_run[0] === 1'b1 && tr_prev !== 1'b1) tr_cnt <= tr_cnt + 1;
    tr_prev <= task_run[0];
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    wr_q.push_back(r);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (int n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
      @(posedge aclk);
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    for (int n = 0; n < 100 && !b_ok; n++) begin
      @(posedge aclk);
      b_ok = s_bvalid === 1'b1;
    end
    // Ready drops after each handshake until the response is taken, and is back high by the next call
    if (!(aw_ok && w_ok && b_ok)) bad_count++;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    logic ar_ok;
    logic r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    rd_q.push_back({r, d});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (int n = 0; n < 100 && !ar_ok; n++) begin
      @(posedge aclk);
      ar_ok = s_arready === 1'b1;
    end
    s_arvalid <= 1'b0;
    for (int n = 0; n < 100 && !r_ok; n++) begin
      @(posedge aclk);
      r_ok = s_rvalid === 1'b1;
    end
    if (!(ar_ok && r_ok)) bad_count++;
  endtask

  // Scan starts land exactly n ms apart; a tick on the start edge is not counted, so tick phase can cost one ms
  task automatic scan(input int n);
    seq.scan_start <= 1'b1;
    @(posedge aclk);
    seq.scan_start <= 1'b0;
    repeat (n * TK - 1) @(posedge aclk);
  endtask
  task automatic ms(input int n);
    repeat (n * TK) @(posedge aclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #1_000_000;
    bad_count++;
    give_verdict();
  end

  initial begin
    seed = 32'h0ed254a0;
    bad_count = 0; checks_done = 0;
    aresetn = 1'b0; seq = '0; manual_reset = 1'b0; power_fail = 1'b0;
    ext_irq = 8'h00; int_irq = 8'h00; s_awaddr = 8'h00; s_wdata = '0;
    s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0;
    s_araddr = 8'h00; s_arvalid = 1'b0; s_rready = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(pss_pkg::A_WD_LIMIT, 32'h00000064, pss_pkg::RESP_OKAY);
    axr(pss_pkg::A_SCAN_MIN, 32'hffffffff, pss_pkg::RESP_OKAY);
    axr(8'h3c, 32'h0, pss_pkg::RESP_SLVERR);
    axw(8'h3c, 32'h1, pss_pkg::RESP_SLVERR);
    rv = $random(seed);
    axw(pss_pkg::A_TMR_PRE, rv, pss_pkg::RESP_OKAY);
    axr(pss_pkg::A_TMR_PRE, rv, pss_pkg::RESP_OKAY);
    cmp_pin({30'h0, exec_enable, outputs_enable}, 32'h0);
    // Run entry, scan statistics
    axw(pss_pkg::A_WD_LIMIT, 32'h0000000a, pss_pkg::RESP_OKAY);
    axw(pss_pkg::A_IRQ_MASK, 32'h00000001, pss_pkg::RESP_OKAY);
    axw(pss_pkg::A_CTRL, 32'h00000001, pss_pkg::RESP_OKAY);
    ms(1);
    cmp_pin(rs_cnt, 32'h1);
    cmp_pin({30'h0, exec_enable, outputs_enable}, 32'h3);
    axr(pss_pkg::A_STATUS, 32'h0000000d, pss_pkg::RESP_OKAY);
    scan(3);
    scan(3);
    scan(5);
    // Still open: a scan is only closed by the next start
    scan(1);
    axr(pss_pkg::A_SCAN_MAX, 32'h5, pss_pkg::RESP_OKAY);
    axr(pss_pkg::A_SCAN_MIN, 32'h3, pss_pkg::RESP_OKAY);
    axr(pss_pkg::A_LATEST_CYCLE_TIME, 32'h5, pss_pkg::RESP_OKAY);
    // Watchdog: clears keep it alive, then an overrun
    scan(8);
    for (int i = 0; i < 3; i++) begin
      seq.wd_clear <= 1'b1;
      @(posedge aclk);
      seq.wd_clear <= 1'b0;
      ms(8);
    end
    cmp_pin({30'h0, exec_enable, outputs_enable}, 32'h3);
    cmp_pin(irq, 32'h0);
    ms(14);
    cmp_pin({30'h0, exec_enable, outputs_enable}, 32'h0);
    cmp_pin(irq, 32'h1);
    scan(1);
    cmp_pin(exec_enable, 32'h0);
    axr(pss_pkg::A_IRQ_STAT, 32'h3, pss_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp_pin(irq, 32'h0);
    manual_reset <= 1'b1;
    @(posedge aclk);
    manual_reset <= 1'b0;
    axr(pss_pkg::A_STATUS, 32'h0, pss_pkg::RESP_OKAY);
    axw(pss_pkg::A_CTRL, 32'h0, pss_pkg::RESP_OKAY);
    ms(1);
    axr(pss_pkg::A_STATUS, 32'h0, pss_pkg::RESP_OKAY);
    // Power loss, short then long
    axw(pss_pkg::A_WD_LIMIT, 32'h00000064, pss_pkg::RESP_OKAY);
    axw(pss_pkg::A_CTRL, 32'h1, pss_pkg::RESP_OKAY);
    scan(1);
    power_fail <= 1'b1;
    ms(10);
    cmp_pin({30'h0, exec_enable, outputs_enable}, 32'h1);
    power_fail <= 1'b0;
    ms(2);
    cmp_pin({30'h0, exec_enable, outputs_enable}, 32'h3);
    cmp_pin(rs_cnt, 32'h2);
    scan(1);
    power_fail <= 1'b1;
    ms(25);
    power_fail <= 1'b0;
    ms(2);
    cmp_pin(rs_cnt, 32'h3);
    // On-delay timer, elapsed moves only at block execution
    scan(1);
    axw(pss_pkg::A_TMR_PRE, 32'h3, pss_pkg::RESP_OKAY);
    axw(pss_pkg::A_CTRL, 32'h3, pss_pkg::RESP_OKAY);
    seq.tmr_in <= 1'b1;
    ms(2);
    seq.tmr_exec <= 1'b1;
    @(posedge aclk);
    seq.tmr_exec <= 1'b0;
    axr(pss_pkg::A_TMR_ET, 32'h2, pss_pkg::RESP_OKAY);
    ms(3);
    axr(pss_pkg::A_TMR_ET, 32'h2, pss_pkg::RESP_OKAY);
    cmp_pin(on_delay_q, 32'h0);
    seq.tmr_exec <= 1'b1;
    @(posedge aclk);
    seq.tmr_exec <= 1'b0;
    repeat (2) @(posedge aclk);
    cmp_pin(on_delay_q, 32'h1);
    // Timed task every 10 ms, then event requests
    scan(1);
    axw(pss_pkg::A_TASK_SEL, 32'h0, pss_pkg::RESP_OKAY);
    axw(pss_pkg::A_TASK_IVL, 32'h1, pss_pkg::RESP_OKAY);
    axw(pss_pkg::A_TASK_ENA, 32'h1, pss_pkg::RESP_OKAY);
    ms(5);
    rv = tr_cnt;
    ms(40);
    cmp_pin(tr_cnt - rv, 32'h4);
    scan(1);
    axw(pss_pkg::A_TASK_ENA, 32'h84, pss_pkg::RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) ext_irq[7] <= 1'b1;
      else int_irq[2] <= 1'b1;
      seen = 1'b0;
      for (int n = 0; n < 20 && !seen; n++) begin
        @(posedge aclk);
        seen = task_run[k ? 2 : 7] === 1'b1;
      end
      ext_irq <= 8'h00;
      int_irq <= 8'h00;
      cmp_pin(seen, 32'h1);
      repeat (4) @(posedge aclk);
    end
    give_verdict();
  end
endmodule
